// File: addr_match_cfg.svh
`ifndef ADDR_MATCH_CFG_SVH
`define ADDR_MATCH_CFG_SVH

// Register byte offsets inside the controller window
`define OWN_ADDRESS_SLOT_0_OFS    8'h04
`define OWN_ADDRESS_SLOT_1_OFS    8'h18
`define OWN_ADDRESS_SLOT_2_OFS    8'h1c
`define OWN_ADDRESS_SLOT_3_OFS    8'h20
`define ADDRESS_DONT_CARE_0_OFS   8'h24
`define ADDRESS_DONT_CARE_1_OFS   8'h28
`define ADDRESS_DONT_CARE_2_OFS   8'h2c
`define ADDRESS_DONT_CARE_3_OFS   8'h30
`define MATCH_STATUS_OFS          8'h34

// Reset values
`define OWN_ADDRESS_SLOT_RESET    8'h00
`define ADDRESS_DONT_CARE_RESET   8'h00

// Field positions
`define OWN_ADDRESS_FIELD_MSB     7
`define OWN_ADDRESS_FIELD_LSB     1
`define GENERAL_CALL_ENABLE_BIT   0
`define DIRECTION_BIT             0

// General call address byte (address zero, write direction)
`define GENERAL_CALL_BYTE         8'h00

// Register index codes from the offset decoder
`define REG_INDEX_STATUS          4'h8
`define REG_INDEX_NONE            4'hf

`endif

// File: addr_match_pkg.sv
package addr_match_pkg;

	// System-domain state of the address matcher
	typedef struct packed {
		logic [3:0][7:0] slot;
		logic [3:0][7:0] mask;
		logic            wr_pend;
		logic [7:0]      wr_ofs;
		logic [31:0]     rdata;
		logic [7:0]      last_byte;
		logic            addressed;
		logic [1:0]      slot_sel;
		logic            gen_call;
		logic            match_pulse;
		logic            res_toggle;
		logic            res_ack;
	} sys_state_t;

	// Link-domain state
	typedef struct packed {
		logic [7:0] byte_q;
		logic       req_toggle;
		logic       result_valid;
		logic       result_ack;
	} link_state_t;

	// Toggle synchroniser state
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} sync_state_t;

endpackage

// File: toggle_crossing.sv
`timescale 1ns/10ps
`default_nettype none

module toggle_crossing
(
	input  wire logic dst_clock,
	input  wire logic dst_rst_n,
	input  wire logic toggle_in,
	output logic      pulse_out
);

	addr_match_pkg::sync_state_t q;
	addr_match_pkg::sync_state_t d;

	// Two flops for the crossing, a third only for edge detection
	always_comb
	begin
		d    = q;
		d.s1 = toggle_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge dst_clock)
	begin
		if (!dst_rst_n)
			q <= '0;
		else
			q <= d;
	end

	// Edge of the synchronised toggle, one destination cycle
	assign pulse_out = q.s2 ^ q.s3;

endmodule

`default_nettype wire

// File: i2c_slave_address_match.sv
// Contract
// RL1 - Address slots are ignored while the controller acts as bus master.
// RL2 - Each slot holds the 7-bit own address in bits 7 to 1.
// RL3 - A received address matching any of four slots makes us addressed. The code never matches the general call byte 0x00 by slot address.
// RL4 - Slot bit 0 set enables general call recognition; cleared disables it.
// RL5 - Mask bits 7 to 1 set make the address bit don't care.
// RL6 - With general call enabled, byte zero with write direction is a match.
`timescale 1ns/10ps
`default_nettype none
`include "addr_match_cfg.svh"

module i2c_slave_address_match
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        master_mode,
	output logic             addr_match,
	output logic [1:0]       match_slot,
	output logic             match_general_call,
	input  wire logic        link_clock,
	input  wire logic        link_rst_n,
	input  wire logic        addr_byte_strobe,
	input  wire logic [7:0]  addr_byte,
	output logic             addr_result_valid,
	output logic             addr_result_ack
);

	addr_match_pkg::sys_state_t  q;
	addr_match_pkg::sys_state_t  d;
	addr_match_pkg::link_state_t lq;
	addr_match_pkg::link_state_t ld;

	logic req_pulse;
	logic res_pulse;

	// Masked compare of the address field against one slot
	function automatic logic slot_hit(input logic [7:0] rx, input logic [7:0] own, input logic [7:0] dc);
		logic [6:0] diff;
		diff = (rx[`OWN_ADDRESS_FIELD_MSB:`OWN_ADDRESS_FIELD_LSB]
		        ^ own[`OWN_ADDRESS_FIELD_MSB:`OWN_ADDRESS_FIELD_LSB])
		       & ~dc[`OWN_ADDRESS_FIELD_MSB:`OWN_ADDRESS_FIELD_LSB];
		return diff == 7'h00;
	endfunction

	// Any slot hit; the general call byte is reserved and never matches by address
	function automatic logic any_hit(input logic [7:0] rx, input addr_match_pkg::sys_state_t s);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 4; i++)
			hit = hit | slot_hit(rx, s.slot[i], s.mask[i]);
		return hit && (rx != `GENERAL_CALL_BYTE);
	endfunction

	// Lowest slot index that hits
	function automatic logic [1:0] first_hit(input logic [7:0] rx, input addr_match_pkg::sys_state_t s);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (slot_hit(rx, s.slot[i], s.mask[i]))
				idx = 2'(i);
		return idx;
	endfunction

	// Lowest slot with general call enabled
	function automatic logic [1:0] first_gc(input addr_match_pkg::sys_state_t s);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (s.slot[i][`GENERAL_CALL_ENABLE_BIT])
				idx = 2'(i);
		return idx;
	endfunction

	// Any slot with general call enabled
	function automatic logic gc_enabled(input addr_match_pkg::sys_state_t s);
		logic en;
		en = 1'b0;
		for (int i = 0; i < 4; i++)
			en = en | s.slot[i][`GENERAL_CALL_ENABLE_BIT];
		return en;
	endfunction

	// Offset to register index; shared by the read and write paths
	function automatic logic [3:0] reg_index(input logic [7:0] ofs);
		logic [3:0] idx;
		unique case (ofs)
			`OWN_ADDRESS_SLOT_0_OFS:  idx = 4'h0;
			`OWN_ADDRESS_SLOT_1_OFS:  idx = 4'h1;
			`OWN_ADDRESS_SLOT_2_OFS:  idx = 4'h2;
			`OWN_ADDRESS_SLOT_3_OFS:  idx = 4'h3;
			`ADDRESS_DONT_CARE_0_OFS: idx = 4'h4;
			`ADDRESS_DONT_CARE_1_OFS: idx = 4'h5;
			`ADDRESS_DONT_CARE_2_OFS: idx = 4'h6;
			`ADDRESS_DONT_CARE_3_OFS: idx = 4'h7;
			`MATCH_STATUS_OFS:        idx = `REG_INDEX_STATUS;
			default:                  idx = `REG_INDEX_NONE;
		endcase
		return idx;
	endfunction

	// Read value; reserved and unmapped bits read as zero
	function automatic logic [31:0] read_value(input logic [7:0] ofs, input addr_match_pkg::sys_state_t s);
		logic [3:0]  idx;
		logic [31:0] v;
		idx = reg_index(ofs);
		v   = 32'h0;
		if (idx < 4'h4)
			v = {24'h0, s.slot[idx[1:0]]};
		else if (idx < `REG_INDEX_STATUS)
			v = {24'h0, s.mask[idx[1:0]]};
		else if (idx == `REG_INDEX_STATUS)
			v = {16'h0, s.last_byte, 4'h0, s.gen_call, s.slot_sel, s.addressed};
		return v;
	endfunction

	// Link side: latch the address byte and flag it with a toggle
	always_comb
	begin
		ld              = lq;
		ld.result_valid = 1'b0;
		// A second strobe before the answer would overwrite byte_q, so the far side must wait
		if (addr_byte_strobe)
		begin
			ld.byte_q     = addr_byte;
			ld.req_toggle = ~lq.req_toggle;
		end
		// Result word was settled before its toggle crossed, so it is stable here
		if (res_pulse)
		begin
			ld.result_valid = 1'b1;
			ld.result_ack   = q.res_ack;
		end
	end

	always_ff @(posedge link_clock)
	begin
		if (!link_rst_n)
			lq <= '0;
		else
			lq <= ld;
	end

	// Byte request into the system domain
	toggle_crossing req_sync
	(
		.dst_clock (clock),
		.dst_rst_n (rst_n),
		.toggle_in (lq.req_toggle),
		.pulse_out (req_pulse)
	);

	// Match result back to the link domain
	toggle_crossing res_sync
	(
		.dst_clock (link_clock),
		.dst_rst_n (link_rst_n),
		.toggle_in (q.res_toggle),
		.pulse_out (res_pulse)
	);

	// System side: register file, bus slave and the compare itself
	always_comb
	begin
		// Write index of the pending data phase, decoded every cycle
		logic [3:0] widx;
		d             = q;
		d.match_pulse = 1'b0;
		// Data phase of a write lands first so a following read sees it
		widx = reg_index(q.wr_ofs);
		if (q.wr_pend)
		begin
			if (widx < 4'h4)
				d.slot[widx[1:0]] = hwdata[7:0];
			else if (widx < `REG_INDEX_STATUS)
				d.mask[widx[1:0]] = {hwdata[7:1], 1'b0};
		end
		// Address phase; read data is fetched now and shown in the data phase
		if (hsel && htrans[1] && hready)
		begin
			d.wr_pend = hwrite;
			d.wr_ofs  = haddr[7:0];
			d.rdata   = hwrite ? 32'h0 : read_value(haddr[7:0], d);
		end
		else
			d.wr_pend = 1'b0;
		// Each received byte is answered, so the link never waits forever
		if (req_pulse)
		begin
			d.last_byte  = lq.byte_q;
			d.res_toggle = ~q.res_toggle;
			d.res_ack    = 1'b0;
			d.addressed  = 1'b0;
			d.gen_call   = 1'b0;
			if (!master_mode) // [RL1]
			begin
				if ((lq.byte_q == `GENERAL_CALL_BYTE) && gc_enabled(q)) // [RL4] [RL6]
				begin
					d.res_ack   = 1'b1;
					d.addressed = 1'b1;
					d.gen_call  = 1'b1;
					d.slot_sel  = first_gc(q);
				end
				else if (any_hit(lq.byte_q, q)) // [RL2] [RL3] [RL5]
				begin
					d.res_ack   = 1'b1;
					d.addressed = 1'b1;
					d.slot_sel  = first_hit(lq.byte_q, q);
				end
			end
			d.match_pulse = d.addressed;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	// Zero wait states, always OKAY
	assign hreadyout          = 1'b1;
	assign hresp              = 1'b0;
	assign hrdata             = q.rdata;
	assign addr_match         = q.match_pulse;
	assign match_slot         = q.slot_sel;
	assign match_general_call = q.gen_call;
	assign addr_result_valid  = lq.result_valid;
	assign addr_result_ack    = lq.result_ack;

	// Helpers for the checks below
	logic [7:0] rx_byte;
	logic       slave_req;
	assign rx_byte   = lq.byte_q;
	assign slave_req = req_pulse && !master_mode;

	master_ignores_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL1]
		(req_pulse && master_mode) |=> (!addr_match && !q.addressed))
		else $error("address matched while in master mode");

	slot0_field_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL2]
		(slave_req && rx_byte != `GENERAL_CALL_BYTE
		 && rx_byte[7:1] == q.slot[0][7:1] && q.slot == $past(q.slot, 1))
		|=> (addr_match && match_slot == 2'h0 && !match_general_call))
		else $error("slot 0 address field not matched");

	no_hit_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL3]
		(slave_req && rx_byte != `GENERAL_CALL_BYTE && !any_hit(rx_byte, q))
		|=> !addr_match ##1 !addr_match)
		else $error("match reported without any slot hit");

	gc_off_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL4]
		(slave_req && rx_byte == `GENERAL_CALL_BYTE && !gc_enabled(q))
		|=> (!addr_match && !match_general_call))
		else $error("general call recognised while disabled");

	mask_all_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL5]
		(slave_req && rx_byte != `GENERAL_CALL_BYTE && q.mask[3][7:1] == 7'h7f)
		|=> addr_match)
		else $error("fully masked slot did not match");

	gc_on_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL6]
		(slave_req && rx_byte == `GENERAL_CALL_BYTE && gc_enabled(q))
		|=> (addr_match && match_general_call) ##1 (!addr_match && match_general_call))
		else $error("general call byte not recognised");

	// One-cycle pulse per matched byte, never without a slave request behind it
	match_needs_req_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL3]
		addr_match |-> $past(slave_req, 1))
		else $error("match reported without a slave request");

	match_single_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL3]
		addr_match |=> !addr_match)
		else $error("match pulse longer than one cycle");

	gc_addressed_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL6]
		match_general_call |-> q.addressed)
		else $error("general call flag without an addressed state");

	gc_needs_enable_a: assert property (@(posedge clock) disable iff (!rst_n) // [RL4]
		(addr_match && match_general_call) |-> $past(gc_enabled(q), 1))
		else $error("general call matched with no slot enabling it");

	// Link side answers exactly once per byte
	result_single_a: assert property (@(posedge link_clock) disable iff (!link_rst_n) // [RL3]
		addr_result_valid |=> !addr_result_valid)
		else $error("link result valid longer than one cycle");

endmodule

`default_nettype wire

// File: far_master.sv
`timescale 1ns/10ps
`default_nettype none

module far_master
(
	input  wire logic       link_clock,
	output logic            addr_byte_strobe,
	output logic [7:0]      addr_byte
);
	// Idle lines at time zero
	initial
	begin
		addr_byte_strobe = 1'b0;
		addr_byte = 8'h5a;
	end

	// One byte per call; the caller waits for its result before the next
	task automatic send(input logic [7:0] b);
		@(posedge link_clock);
		addr_byte_strobe <= 1'b1;
		addr_byte <= b;
		@(posedge link_clock);
		addr_byte_strobe <= 1'b0;
		// Inverse after release, so a stale byte can never pass for a fresh one
		addr_byte <= ~b;
	endtask
endmodule

`default_nettype wire

// File: test_i2c_slave_address_match.sv
`timescale 1ns/10ps
`default_nettype none

module test_i2c_slave_address_match;
	logic        clock, link_clock, rst_n, link_rst_n, hsel, hwrite, hreadyout, hresp;
	logic        master_mode, addr_match, match_general_call, addr_byte_strobe;
	logic        addr_result_valid, addr_result_ack, seen_gc;
	logic [1:0]  htrans, match_slot, seen_slot;
	logic [2:0]  hsize;
	logic [7:0]  addr_byte;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          err_count, tests_run, match_count;
	logic [7:0]  ofs [8] = '{8'h04, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};

	i2c_slave_address_match i_dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .master_mode(master_mode),
		.addr_match(addr_match), .match_slot(match_slot), .match_general_call(match_general_call),
		.link_clock(link_clock), .link_rst_n(link_rst_n), .addr_byte_strobe(addr_byte_strobe),
		.addr_byte(addr_byte), .addr_result_valid(addr_result_valid),
		.addr_result_ack(addr_result_ack));

	far_master i_far (.link_clock(link_clock), .addr_byte_strobe(addr_byte_strobe),
		.addr_byte(addr_byte));

	// System clock, 10 ns
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Link clock, 6 ns, phase unrelated to the system clock
	initial
	begin
		link_clock = 1'b0;
		#1.7;
		forever #3 link_clock = ~link_clock;
	end

	// Latch the system result, which lives for one cycle only
	always @(posedge clock)
		if (addr_match === 1'b1)
		begin
			match_count <= match_count + 1;
			seen_slot <= match_slot;
			seen_gc <= match_general_call;
		end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	// One single AHB transfer; read data is taken at the data phase edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h00000000);
		chk("register", e, rd);
		chk("response", 32'h00000000, {31'h0, hresp});
	endtask

	// Send one byte, wait for the link result and judge both domains
	task automatic bchk(input logic [7:0] b, input logic a, input logic [1:0] s, input logic g);
		int n;
		int m;
		n = 0;
		m = match_count;
		i_far.send(b);
		while (addr_result_valid !== 1'b1 && n < 50)
		begin
			@(posedge link_clock);
			n++;
		end
		chk("result valid", 32'h1, {31'h0, addr_result_valid});
		chk("ack", {31'h0, a}, {31'h0, addr_result_ack});
		chk("match", {31'h0, a}, 32'(match_count - m));
		if (a)
		begin
			chk("slot", {30'h0, s}, {30'h0, seen_slot});
			chk("general call", {31'h0, g}, {31'h0, seen_gc});
		end
	endtask

	task automatic t_regs;
		foreach (ofs[i])
			rchk(ofs[i], 32'h00000000);
		xfer(1'b1, 8'h04, 32'hffffffff);
		rchk(8'h04, 32'h000000ff);
		xfer(1'b1, 8'h24, 32'hffffffff);
		rchk(8'h24, 32'h000000fe);
		xfer(1'b1, 8'h10, 32'h00000055);
		rchk(8'h10, 32'h00000000);
	endtask

	task automatic t_addr;
		xfer(1'b1, 8'h04, 32'h00000010);
		xfer(1'b1, 8'h24, 32'h00000000);
		xfer(1'b1, 8'h18, 32'h00000062);
		xfer(1'b1, 8'h20, 32'h000000c8);
		bchk(8'h62, 1'b1, 2'h1, 1'b0);
		bchk(8'h63, 1'b1, 2'h1, 1'b0);
		bchk(8'h64, 1'b0, 2'h0, 1'b0);
		bchk(8'hc8, 1'b1, 2'h3, 1'b0);
		bchk(8'h11, 1'b1, 2'h0, 1'b0);
	endtask

	task automatic t_mask;
		xfer(1'b1, 8'h1c, 32'h00000080);
		xfer(1'b1, 8'h2c, 32'h00000006);
		bchk(8'h86, 1'b1, 2'h2, 1'b0);
		bchk(8'h88, 1'b0, 2'h0, 1'b0);
		bchk(8'h12, 1'b0, 2'h0, 1'b0);
		xfer(1'b1, 8'h24, 32'h00000002);
		bchk(8'h12, 1'b1, 2'h0, 1'b0);
		xfer(1'b1, 8'h30, 32'h000000fe);
		bchk(8'h88, 1'b1, 2'h3, 1'b0);
		xfer(1'b1, 8'h30, 32'h00000000);
	endtask

	task automatic t_gc;
		bchk(8'h00, 1'b0, 2'h0, 1'b0);
		xfer(1'b1, 8'h1c, 32'h00000081);
		bchk(8'h00, 1'b1, 2'h2, 1'b1);
		rchk(8'h34, 32'h0000000d);
		bchk(8'h01, 1'b0, 2'h0, 1'b0);
		xfer(1'b1, 8'h1c, 32'h00000080);
		bchk(8'h00, 1'b0, 2'h0, 1'b0);
	endtask

	task automatic t_master;
		@(posedge clock);
		master_mode <= 1'b1;
		bchk(8'h62, 1'b0, 2'h0, 1'b0);
		@(posedge clock);
		master_mode <= 1'b0;
		bchk(8'h62, 1'b1, 2'h1, 1'b0);
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Both resets released together, after two system and two link edges
	initial
	begin
		rst_n = 1'b0;
		link_rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		master_mode = 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		link_rst_n <= 1'b1;
		repeat (2) @(posedge clock);
		t_regs;
		t_addr;
		t_mask;
		t_gc;
		t_master;
		conclude;
	end

	// Hang guard, far beyond the expected few microseconds
	initial
	begin
		#50000;
		err_count++;
		conclude;
	end
endmodule

`default_nettype wire
